// *** tlic_pkg.sv ***
package tlic_pkg;

  // register indices; byte address is four times the index
  localparam logic [15:0] SYSCTL_IDX = 16'hFFF2;
  localparam logic [15:0] SENSE_IDX = 16'hFFF4;
  localparam logic [15:0] ENABLE_IDX = 16'hFFF5;
  localparam logic [15:0] FLAGS_IDX = 16'hFFF6;
  localparam logic [15:0] PRIA_IDX = 16'hFFF8;
  localparam logic [15:0] PRIB_IDX = 16'hFFF9;

  // values after reset
  localparam logic [7:0] SYSCTL_RST = 8'h0B;
  localparam logic [7:0] REG_RST = 8'h00;

  // field positions
  localparam int USER_EN_BIT = 3;
  localparam int NMI_EDGE_BIT = 2;
  localparam int COND_I_BIT = 7;
  localparam int COND_UMASK_BIT = 6;

  // vectors
  localparam logic [5:0] VEC_NMI = 6'h07;
  localparam logic [5:0] VEC_TRAP0 = 6'h08;
  localparam logic [5:0] VEC_EXT0 = 6'h0C;
  localparam logic [5:0] VEC_INT0 = 6'h14;

  localparam int N_EXT = 6;
  localparam int N_INT = 30;
  localparam int N_SRC = 36;
  localparam logic [5:0] N_EXT6 = 6'h06;

  // per source: bit of {priority_level_a, priority_level_b} giving its level
  localparam logic [N_SRC-1:0][3:0] SRC_LVL_BIT = {
    4'h1, {4{4'h2}}, {4{4'h3}}, {4{4'h5}}, {3{4'h6}}, {3{4'h7}},
    {3{4'h8}}, {3{4'h9}}, {3{4'hA}}, {2{4'hB}}, {2{4'hC}}, {2{4'hD}},
    4'hE, 4'hF};

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {SQ_IDLE, SQ_PUSH, SQ_VEC} tlic_seq_t;

  typedef struct packed {
    logic awvalid;
    logic [31:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [31:0] araddr;
    logic rready;
  } tlic_axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } tlic_axi_rsp_t;

  typedef struct packed {
    logic [31:0] sp;
    logic [23:0] pc;
    logic [7:0] condition_code_register;
    logic boundary;
    logic trap_req;
    logic [1:0] trap_num;
  } tlic_cpu_in_t;

  typedef struct packed {
    logic busy;
    logic mem_wr;
    logic mem_rd;
    logic [31:0] mem_addr;
    logic [31:0] mem_wdata;
    logic ccr_load;
    logic [7:0] ccr_new;
    logic [31:0] sp_new;
    logic [5:0] vector;
  } tlic_cpu_out_t;

endpackage

// *** tlic_top.sv ***
// Behaviour
// - nonmaskable request beats all others, ignores mask bits and levels
// - each maskable module sits at low or high level; simultaneous arbitrated
// - six maskable pins, one nonmaskable pin, thirty internal requests
// - every source has its own vector number
// - I and user mask bit give three levels; it masks only with enable 0
// - trap sets I; with user_bit_enable clear sets I and user mask bit
// - trap vector chosen by the two-bit number in the instruction
// - word and longword stack addresses have bit zero forced low
// - nonmaskable edge: falling when select bit 0, rising when 1
// - each maskable pin senses falling edge or low level on its own
// - user_bit_enable 0 makes user bit a mask, 1 a plain bit; resets 1
// - system control loads 0B on reset and hardware standby
// - level bits a7 and a6 set levels of pins 0 and 1
// - level bit a5 covers pins 2 and 3, a4 pins 4 and 5
// - level bit a3 covers watchdog and refresh, a2 timer channel 0
// - priority level a clears to 00 on reset and hardware standby
// - status flags ignore written ones; written zero after read clears
// - watchdog overflow and refresh compare requests arrive as inputs
// - exception pushes PC and condition codes, sets I, fetches vector
// - flag sets on low level or on high-to-low edge
`timescale 1ns/100ps
module tlic_top
  import tlic_pkg::*;
(
  // clock, reset, standby
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic hw_stby,
  // request pins
  input wire logic nmi_pin,
  input wire logic [N_EXT-1:0] ext_req_b,
  // on-chip module requests
  input wire logic [N_INT-1:0] int_req,
  // cpu exception port
  input wire tlic_cpu_in_t cpu_i,
  output tlic_cpu_out_t cpu_o,
  // register bus
  input wire tlic_axi_req_t axi_i,
  output tlic_axi_rsp_t axi_o
);

  typedef struct packed {
    logic [7:0] sysctl;
    logic [7:0] sense;
    logic [7:0] enable;
    logic [N_EXT-1:0] flags;
    logic [N_EXT-1:0] rd_seen;
    logic [7:0] pria;
    logic [7:0] prib;
    logic nmi_prev;
    logic nmi_flag;
    logic [N_EXT-1:0] ext_prev;
    tlic_seq_t seq;
    logic aw_got;
    logic aw_ok;
    logic [15:0] aw_idx;
    logic w_got;
    logic [7:0] w_byte;
    logic w_lane0;
    tlic_axi_rsp_t ax;
    tlic_cpu_out_t o;
  } tlic_state_t;

  tlic_state_t st_q;
  tlic_state_t st_d;

  logic [15:0] lvl_word;
  logic [N_SRC-1:0] pend;
  logic [N_SRC-1:0] lvl;
  logic [N_SRC-1:0] hi_set;
  logic [N_SRC-1:0] lo_set;
  logic mask_all;
  logic mask_low;
  logic int_win;
  logic [5:0] win_src;
  logic int_go;
  logic trap_go;
  logic [5:0] go_vec;

  function automatic logic in_map(input logic [31:0] a);
    logic [15:0] i;
    i = a[17:2];
    in_map = (a[31:18] == 14'h0000) && (a[1:0] == 2'h0) &&
      (i == SYSCTL_IDX || i == SENSE_IDX || i == ENABLE_IDX ||
       i == FLAGS_IDX || i == PRIA_IDX || i == PRIB_IDX);
  endfunction

  function automatic logic [6:0] first_set(input logic [N_SRC-1:0] v);
    first_set = 7'h00;
    for (int k = N_SRC - 1; k >= 0; k--)
    begin
      if (v[k])
      begin
        first_set = {1'b1, 6'(k)};
      end
    end
  endfunction

  function automatic logic [5:0] src_vec(input logic [5:0] s);
    if (s < N_EXT6)
    begin
      src_vec = VEC_EXT0 + s;
    end
    else
    begin
      src_vec = VEC_INT0 + (s - N_EXT6);
    end
  endfunction

  // level lookup per source
  assign lvl_word = {st_q.pria, st_q.prib};
  generate
    for (genvar g = 0; g < N_SRC; g++)
    begin : g_lvl
      assign lvl[g] = lvl_word[SRC_LVL_BIT[g]];
    end
  endgenerate

  always_comb
  begin
    // internal requests are levels held by their own modules
    pend = {int_req, st_q.flags & st_q.enable[N_EXT-1:0]};
    mask_all = cpu_i.condition_code_register[COND_I_BIT] &&
      (st_q.sysctl[USER_EN_BIT] || cpu_i.condition_code_register[COND_UMASK_BIT]);
    mask_low = cpu_i.condition_code_register[COND_I_BIT] && !st_q.sysctl[USER_EN_BIT] &&
      !cpu_i.condition_code_register[COND_UMASK_BIT];
    hi_set = mask_all ? '0 : (pend & lvl);
    lo_set = (mask_all || mask_low) ? '0 : (pend & ~lvl);
    if (|hi_set)
    begin
      {int_win, win_src} = first_set(hi_set);
    end
    else
    begin
      {int_win, win_src} = first_set(lo_set);
    end
    // no new sequence while busy is still up from the last one
    int_go = st_q.seq == SQ_IDLE && !st_q.o.busy && cpu_i.boundary &&
      (st_q.nmi_flag || int_win);
    trap_go = st_q.seq == SQ_IDLE && !st_q.o.busy && !int_go &&
      cpu_i.trap_req;
    if (int_go && st_q.nmi_flag)
    begin
      go_vec = VEC_NMI;
    end
    else if (int_go)
    begin
      go_vec = src_vec(win_src);
    end
    else
    begin
      go_vec = VEC_TRAP0 + {4'h0, cpu_i.trap_num};
    end
  end

  always_comb
  begin
    st_d = st_q;
    st_d.o.mem_wr = 1'b0;
    st_d.o.mem_rd = 1'b0;
    st_d.o.ccr_load = 1'b0;

    // pin sensing
    st_d.nmi_prev = nmi_pin;
    st_d.ext_prev = ext_req_b;

    // exception sequencer
    case (st_q.seq)
      SQ_IDLE:
      begin
        st_d.o.busy = 1'b0;
        if (int_go || trap_go)
        begin
          st_d.seq = SQ_PUSH;
          st_d.o.busy = 1'b1;
          st_d.o.vector = go_vec;
          if (int_go && st_q.nmi_flag)
          begin
            st_d.nmi_flag = 1'b0;
          end
          else if (int_go && win_src < N_EXT6)
          begin
            st_d.flags[win_src[2:0]] = 1'b0;
          end
        end
      end
      SQ_PUSH:
      begin
        st_d.seq = SQ_VEC;
        st_d.o.mem_wr = 1'b1;
        st_d.o.mem_addr = {cpu_i.sp[31:1] - 31'h00000002, 1'b0};
        st_d.o.sp_new = {cpu_i.sp[31:1] - 31'h00000002, 1'b0};
        st_d.o.mem_wdata = {cpu_i.condition_code_register, cpu_i.pc};
        st_d.o.ccr_load = 1'b1;
        st_d.o.ccr_new = cpu_i.condition_code_register;
        st_d.o.ccr_new[COND_I_BIT] = 1'b1;
        if (!st_q.sysctl[USER_EN_BIT])
        begin
          st_d.o.ccr_new[COND_UMASK_BIT] = 1'b1;
        end
      end
      SQ_VEC:
      begin
        st_d.seq = SQ_IDLE;
        st_d.o.mem_rd = 1'b1;
        st_d.o.mem_addr = {24'h000000, st_q.o.vector, 2'h0};
      end
      default:
      begin
        st_d.seq = SQ_IDLE;
      end
    endcase

    // bus write side
    if (axi_i.awvalid && st_q.ax.awready)
    begin
      st_d.aw_got = 1'b1;
      st_d.aw_ok = in_map(axi_i.awaddr);
      st_d.aw_idx = axi_i.awaddr[17:2];
    end
    if (axi_i.wvalid && st_q.ax.wready)
    begin
      st_d.w_got = 1'b1;
      st_d.w_byte = axi_i.wdata[7:0];
      st_d.w_lane0 = axi_i.wstrb[0];
    end
    if (st_q.aw_got && st_q.w_got && !st_q.ax.bvalid)
    begin
      st_d.ax.bvalid = 1'b1;
      st_d.ax.bresp = st_q.aw_ok ? RESP_OKAY : RESP_SLVERR;
      if (st_q.aw_ok && st_q.w_lane0)
      begin
        case (st_q.aw_idx)
          SYSCTL_IDX: st_d.sysctl = st_q.w_byte;
          SENSE_IDX: st_d.sense = st_q.w_byte;
          ENABLE_IDX: st_d.enable = st_q.w_byte;
          PRIA_IDX: st_d.pria = st_q.w_byte;
          PRIB_IDX: st_d.prib = st_q.w_byte;
          FLAGS_IDX:
          begin
            // ones are ignored, zeros clear only a flag read as one
            for (int n = 0; n < N_EXT; n++)
            begin
              if (!st_q.w_byte[n] && st_q.rd_seen[n])
              begin
                st_d.flags[n] = 1'b0;
                st_d.rd_seen[n] = 1'b0;
              end
            end
          end
          default:
          begin
            st_d.sense = st_d.sense;
          end
        endcase
      end
    end
    if (st_q.ax.bvalid && axi_i.bready)
    begin
      st_d.ax.bvalid = 1'b0;
      st_d.aw_got = 1'b0;
      st_d.w_got = 1'b0;
    end
    st_d.ax.awready = !st_d.aw_got;
    st_d.ax.wready = !st_d.w_got;

    // bus read side
    if (axi_i.arvalid && st_q.ax.arready)
    begin
      st_d.ax.rvalid = 1'b1;
      st_d.ax.rresp = in_map(axi_i.araddr) ? RESP_OKAY : RESP_SLVERR;
      st_d.ax.rdata = 32'h00000000;
      if (in_map(axi_i.araddr))
      begin
        case (axi_i.araddr[17:2])
          SYSCTL_IDX: st_d.ax.rdata[7:0] = st_q.sysctl;
          SENSE_IDX: st_d.ax.rdata[7:0] = st_q.sense;
          ENABLE_IDX: st_d.ax.rdata[7:0] = st_q.enable;
          PRIA_IDX: st_d.ax.rdata[7:0] = st_q.pria;
          PRIB_IDX: st_d.ax.rdata[7:0] = st_q.prib;
          default:
          begin
            st_d.ax.rdata[N_EXT-1:0] = st_q.flags;
            st_d.rd_seen = st_d.rd_seen | st_q.flags;
          end
        endcase
      end
    end
    else if (st_q.ax.rvalid && axi_i.rready)
    begin
      st_d.ax.rvalid = 1'b0;
    end
    st_d.ax.arready = !st_d.ax.rvalid;

    // flag setting wins over any clear above
    for (int n = 0; n < N_EXT; n++)
    begin
      if (st_q.sense[n] ? (!ext_req_b[n] && st_q.ext_prev[n])
          : !ext_req_b[n])
      begin
        st_d.flags[n] = 1'b1;
      end
    end
    if (st_q.sysctl[NMI_EDGE_BIT] ? (nmi_pin && !st_q.nmi_prev)
        : (!nmi_pin && st_q.nmi_prev))
    begin
      st_d.nmi_flag = 1'b1;
    end

    // hardware standby reloads the registers
    if (hw_stby)
    begin
      st_d.sysctl = SYSCTL_RST;
      st_d.sense = REG_RST;
      st_d.enable = REG_RST;
      st_d.flags = '0;
      st_d.rd_seen = '0;
      st_d.pria = REG_RST;
      st_d.prib = REG_RST;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      st_q <= '0;
      st_q.sysctl <= SYSCTL_RST;
      st_q.nmi_prev <= 1'b1;
      st_q.ext_prev <= '1;
      st_q.ax.awready <= 1'b1;
      st_q.ax.wready <= 1'b1;
      st_q.ax.arready <= 1'b1;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign cpu_o = st_q.o;
  assign axi_o = st_q.ax;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_b);

  a_nmi_first: assert property (
    st_q.seq == SQ_IDLE && st_q.nmi_flag && cpu_i.boundary
    |=> st_q.o.vector == VEC_NMI && st_q.seq == SQ_PUSH)
    else $error("nmi not taken first");

  a_trap_ccr: assert property (
    trap_go && !st_q.sysctl[USER_EN_BIT]
    |-> ##2 st_q.o.ccr_load && st_q.o.ccr_new[COND_I_BIT] &&
    st_q.o.ccr_new[COND_UMASK_BIT])
    else $error("trap did not set both mask bits");

  a_trap_vec: assert property (
    trap_go |=> st_q.o.vector == VEC_TRAP0 + {4'h0, $past(cpu_i.trap_num)})
    else $error("wrong trap vector");

  a_even_addr: assert property (
    st_q.o.mem_wr || st_q.o.mem_rd |-> !st_q.o.mem_addr[0])
    else $error("odd exception address");

  a_level_set: assert property (
    !hw_stby && !st_q.sense[0] && !ext_req_b[0] |=> st_q.flags[0])
    else $error("level request lost");

  a_mask_all: assert property (
    st_q.seq == SQ_IDLE && mask_all && !st_q.nmi_flag && !cpu_i.trap_req
    |=> st_q.seq == SQ_IDLE)
    else $error("masked request accepted");

  a_push_frame: assert property (
    st_q.o.mem_wr |=> st_q.o.mem_rd &&
    st_q.o.mem_addr == {24'h000000, st_q.o.vector, 2'h0} ##1 !st_q.o.busy)
    else $error("vector fetch out of order");

  a_stby_load: assert property (
    hw_stby |=> st_q.sysctl == SYSCTL_RST && st_q.pria == REG_RST)
    else $error("standby did not reload");

  c_nmi_seq: cover property (int_go && st_q.nmi_flag ##4 !st_q.o.busy);
  c_trap_seq: cover property (trap_go ##1 st_q.seq == SQ_PUSH);
  c_ext_hi: cover property (int_go && |hi_set && win_src < N_EXT6);

endmodule

// *** tlic_cpu_model.sv ***
`timescale 1ns/100ps
module tlic_cpu_model
  import tlic_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // controller side
  input wire tlic_cpu_out_t cpu_o,
  output tlic_cpu_in_t cpu_i,
  // bench control
  input wire logic ld,
  input wire logic [7:0] ld_ccr,
  input wire logic [31:0] ld_sp,
  input wire logic trap_go,
  input wire logic [1:0] trap_n
);
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      cpu_i <= '0;
      cpu_i.condition_code_register <= 8'h80;
      cpu_i.sp <= 32'h0000_1000;
      cpu_i.pc <= 24'h001234;
    end
    else
    begin
      cpu_i.boundary <= !cpu_o.busy;
      // bench load wins over the sequencer's update
      if (ld)
      begin
        cpu_i.condition_code_register <= ld_ccr;
        cpu_i.sp <= ld_sp;
      end
      else if (cpu_o.ccr_load)
      begin
        cpu_i.condition_code_register <= cpu_o.ccr_new;
        cpu_i.sp <= cpu_o.sp_new;
      end
      // trap level held until the sequence starts
      if (trap_go)
      begin
        cpu_i.trap_req <= 1'b1;
        cpu_i.trap_num <= trap_n;
      end
      else if (cpu_o.busy)
        cpu_i.trap_req <= 1'b0;
    end
  end
endmodule

// *** tlic_tb_top.sv ***
`timescale 1ns/100ps
module tlic_tb_top
  import tlic_pkg::*;
;
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic hw_stby = 1'b0;
  logic nmi_pin = 1'b1;
  logic [N_EXT-1:0] ext_req_b = '1;
  logic [N_INT-1:0] int_req = '0;
  tlic_cpu_in_t cpu_i;
  tlic_cpu_out_t cpu_o;
  tlic_axi_req_t axi_i = '0;
  tlic_axi_rsp_t axi_o;
  logic ld = 1'b0;
  logic [7:0] ld_ccr = 8'h00;
  logic [31:0] ld_sp = 32'h0;
  logic trap_go = 1'b0;
  logic [1:0] trap_n = 2'h0;
  logic ube = 1'b1;
  int num_errors = 0;
  int samples_checked = 0;
  logic [33:0] rq[$];
  logic [109:0] eq[$];
  logic [1:0] wq[$];

  always #50 mclk = ~mclk;

  tlic_top dut (.mclk(mclk), .rst_b(rst_b), .hw_stby(hw_stby),
    .nmi_pin(nmi_pin), .ext_req_b(ext_req_b), .int_req(int_req),
    .cpu_i(cpu_i), .cpu_o(cpu_o), .axi_i(axi_i), .axi_o(axi_o));
  tlic_cpu_model cpu (.mclk(mclk), .rst_b(rst_b), .cpu_o(cpu_o),
    .cpu_i(cpu_i), .ld(ld), .ld_ccr(ld_ccr), .ld_sp(ld_sp),
    .trap_go(trap_go), .trap_n(trap_n));

  task automatic bad(input logic [109:0] g, input logic [109:0] e);
    num_errors++;
    $display("wrong value at %0t: got %h expected %h", $time, g, e);
  endtask
  task automatic chk_rd(input logic [33:0] g, input logic [33:0] e);
    samples_checked++;
    if (g !== e)
      bad(110'(g), 110'(e));
  endtask
  task automatic chk_exc(input logic [109:0] g, input logic [109:0] e);
    samples_checked++;
    if (g !== e)
      bad(g, e);
  endtask
  task automatic summarize;
    $display("checked %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic hang;
    num_errors++;
    summarize;
  endtask

  // results are compared against the oldest note
  always @(posedge mclk)
  begin
    if (axi_o.rvalid === 1'b1 && axi_i.rready === 1'b1)
      if (rq.size() > 0)
        chk_rd({axi_o.rresp, axi_o.rdata}, rq.pop_front());
      else
        bad(110'({axi_o.rresp, axi_o.rdata}), 110'h0);
    if (axi_o.bvalid === 1'b1 && axi_i.bready === 1'b1)
      if (wq.size() > 0)
        chk_rd({axi_o.bresp, 32'h0}, {wq.pop_front(), 32'h0});
      else
        bad(110'(axi_o.bresp), 110'h0);
    if (cpu_o.ccr_load === 1'b1)
      if (eq.size() > 0)
        chk_exc({cpu_o.vector, cpu_o.ccr_new, cpu_o.mem_addr,
          cpu_o.mem_wdata, cpu_o.sp_new}, eq.pop_front());
      else
        bad(110'({cpu_o.vector, cpu_o.ccr_new}), 110'h0);
  end

  function automatic logic [31:0] ba(input logic [15:0] i);
    return {14'h0, i, 2'h0};
  endfunction
  function automatic logic [33:0] ok(input logic [7:0] v);
    return {RESP_OKAY, 24'h0, v};
  endfunction

  task automatic axw(input logic [31:0] a, input logic [7:0] d);
    int n;
    n = 0;
    wq.push_back(RESP_OKAY);
    axi_i.awaddr <= a;
    axi_i.wdata <= {24'h0, d};
    axi_i.wstrb <= 4'hF;
    axi_i.awvalid <= 1'b1;
    axi_i.wvalid <= 1'b1;
    axi_i.bready <= 1'b1;
    do
    begin
      @(posedge mclk);
      n++;
      if (axi_o.awready === 1'b1)
        axi_i.awvalid <= 1'b0;
      if (axi_o.wready === 1'b1)
        axi_i.wvalid <= 1'b0;
    end
    while (axi_o.bvalid !== 1'b1 && n < 50);
    axi_i.bready <= 1'b0;
    if (n >= 50)
      hang;
    @(posedge mclk);
  endtask
  task automatic axr(input logic [31:0] a, input logic [33:0] e);
    int n;
    n = 0;
    rq.push_back(e);
    axi_i.araddr <= a;
    axi_i.arvalid <= 1'b1;
    axi_i.rready <= 1'b1;
    do
    begin
      @(posedge mclk);
      n++;
      if (axi_o.arready === 1'b1)
        axi_i.arvalid <= 1'b0;
    end
    while (axi_o.rvalid !== 1'b1 && n < 50);
    axi_i.rready <= 1'b0;
    if (n >= 50)
      hang;
    @(posedge mclk);
  endtask
  // vector 0 loads the cpu without noting a result
  task automatic expx(input logic [5:0] v, input logic [7:0] c,
    input logic [31:0] sp);
    if (v != 6'h00)
      eq.push_back({v, c | (ube ? 8'h80 : 8'hC0), (sp - 32'h4) & ~32'h1,
        {c, 24'h001234}, (sp - 32'h4) & ~32'h1});
    ld_ccr <= c;
    ld_sp <= sp;
    ld <= 1'b1;
    @(posedge mclk);
    ld <= 1'b0;
  endtask
  task automatic trap(input logic [1:0] n);
    trap_go <= 1'b1;
    trap_n <= n;
    @(posedge mclk);
    trap_go <= 1'b0;
  endtask
  task automatic wexc;
    int n;
    n = 0;
    while (eq.size() > 0 && n < 60)
    begin
      @(posedge mclk);
      n++;
    end
    if (n >= 60)
      hang;
    repeat (4) @(posedge mclk);
  endtask

  initial
  begin
    int idx;
    logic [15:0] ix[6];
    ix = '{SYSCTL_IDX, SENSE_IDX, ENABLE_IDX, FLAGS_IDX, PRIA_IDX, PRIB_IDX};
    void'($urandom(32'h8BFA));
    repeat (10) @(posedge mclk);
    rst_b <= 1'b1;
    @(posedge mclk);
    foreach (ix[i])
      axr(ba(ix[i]), ok(i == 0 ? SYSCTL_RST : REG_RST));
    axr(32'h0000_0100, {RESP_SLVERR, 32'h0});
    axw(ba(PRIA_IDX), 8'hC3);
    axw(ba(SYSCTL_IDX), 8'h07);
    axr(ba(PRIA_IDX), ok(8'hC3));
    hw_stby <= 1'b1;
    @(posedge mclk);
    hw_stby <= 1'b0;
    axr(ba(PRIA_IDX), ok(8'h00));
    axr(ba(SYSCTL_IDX), ok(8'h0B));
    $display("test registers done");
    for (int n = 0; n < 4; n++)
    begin
      expx(VEC_TRAP0 + 6'(n), 8'h00, 32'h2001 + 32'(n));
      trap(2'(n));
      wexc;
    end
    axw(ba(SYSCTL_IDX), 8'h03);
    ube = 1'b0;
    expx(VEC_TRAP0 + 6'h1, 8'h00, 32'h3000);
    trap(2'h1);
    wexc;
    $display("test traps done");
    expx(VEC_NMI, 8'hC0, 32'h1000);
    nmi_pin <= 1'b0;
    wexc;
    axw(ba(SYSCTL_IDX), 8'h07);
    expx(VEC_NMI, 8'hC0, 32'h1000);
    nmi_pin <= 1'b1;
    wexc;
    $display("test nonmaskable done");
    axw(ba(ENABLE_IDX), 8'h03);
    axw(ba(PRIA_IDX), 8'h40);
    ext_req_b <= 6'h3C;
    repeat (3) @(posedge mclk);
    ext_req_b <= 6'h3F;
    expx(VEC_EXT0 + 6'h1, 8'h00, 32'h1000);
    wexc;
    expx(VEC_EXT0, 8'h00, 32'h1000);
    wexc;
    $display("test external done");
    idx = $urandom % N_INT;
    // low-level source held off by I while the user bit is a mask
    expx(6'h00, 8'h80, 32'h1000);
    int_req[idx] <= 1'b1;
    repeat (20) @(posedge mclk);
    axw(ba(SYSCTL_IDX), 8'h0B);
    repeat (10) @(posedge mclk);
    ube = 1'b1;
    expx(VEC_INT0 + 6'(idx), 8'h40, 32'h1000);
    wexc;
    int_req[idx] <= 1'b0;
    $display("test internal done");
    summarize;
  end
endmodule
